//--- hdl/daalic_pkg.sv
/*
 Constants of the line interface controller.
 Assumes one 25 MHz core clock on both ends.
*/
package daalic_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int PLL_LOCK_US = 1000;
    localparam int PLL_LOCK_CYC = (CLK_HZ / 1_000_000) * PLL_LOCK_US;
    localparam logic [10:0] OFFHOOK_SETTLE_SAMPLES = 11'h60c;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int CODE_W = 5;

    // link register indices
    localparam logic [4:0] REG_CTRL1 = 5'h05;
    localparam logic [4:0] REG_LINE16 = 5'h10;
    localparam logic [4:0] REG_LINE17 = 5'h11;
    localparam logic [4:0] REG_LINE18 = 5'h12;
    localparam logic [4:0] REG_SENSE19 = 5'h13;

    localparam int CTRL1_HOOK_BIT = 0;
    localparam int CTRL1_MONITOR_BIT = 3;
    localparam int CTRL1_MODE_BIT = 4;
    localparam logic [7:0] CTRL1_RESET = 8'h00;

    // second control register lives on the system side
    localparam int CTRL2_LINK_PD_BIT = 3;
    localparam int CTRL2_MON_OFF_BIT = 1;
    localparam logic [7:0] CTRL2_RESET = 8'h0a;
    localparam logic [7:0] CTRL2_POWER_ON = 8'h00;

    localparam int L16_PAR_BIT = 0;
    localparam int L16_RING_BIT = 1;
    localparam int L16_DCT_LSB = 2;
    localparam int L16_ACT_BIT = 4;
    localparam int L16_HS_BIT = 6;
    localparam logic [7:0] L16_RESET = 8'h08;
    localparam int L17_CAP_BIT = 1;
    localparam logic [7:0] L17_RESET = 8'h00;
    localparam int L18_RLV_BIT = 0;
    localparam int L18_FULL_BIT = 4;
    localparam logic [7:0] L18_RESET = 8'h00;
    localparam int S19_CODE_LSB = 0;
    localparam int S19_DROPOUT_BIT = 7;

    localparam logic [1:0] DCT_LOWV = 2'h0;
    localparam logic [1:0] DCT_JAPAN = 2'h1;
    localparam logic [1:0] DCT_FCC = 2'h2;
    localparam logic [1:0] DCT_CTR21 = 2'h3;

    // transmit/receive full scale selections
    localparam logic [2:0] FS_M1_DBM = 3'h0;
    localparam logic [2:0] FS_P3P2_DBM = 3'h1;
    localparam logic [2:0] FS_M2P71_DBM = 3'h2;
    localparam logic [2:0] FS_M5_DBM = 3'h3;

    // line voltage in quarter volts, loop current in mA
    localparam logic [8:0] LV_ZERO_QV = 9'h00c;
    localparam logic [8:0] LV_STEP_QV = 9'h00b;
    localparam logic [8:0] LV_FULL_QV = 9'h15c;
    localparam logic [7:0] LC_STEP_MA = 8'h03;
    localparam logic [7:0] LC_OVER_MA = 8'h8c;
    localparam logic [7:0] LC_OVER_CTR21_MA = 8'h36;
    localparam logic [7:0] LC_CAP_MA = 8'h3c;
    localparam logic [4:0] CODE_ZERO = 5'h00;
    localparam logic [4:0] CODE_TOP = 5'h1e;
    localparam logic [4:0] CODE_OVER = 5'h1f;

    localparam logic [7:0] LINE_SIDE_ID = 8'h5a; // arbitrary value
    localparam logic [7:0] RATE_RESET = 8'h9b;
    localparam logic [3:0] SAMPLE_SUB_MAX = 4'hf;

    // wishbone byte offsets of the controller
    localparam logic [7:0] WB_CTRL = 8'h00;
    localparam logic [7:0] WB_CFG = 8'h04;
    localparam logic [7:0] WB_STAT = 8'h08;
    localparam int WC_START = 0;
    localparam int WC_HOOK = 1;
    localparam int WC_FULL = 2;
    localparam int WC_PAR = 3;
    localparam int WC_MODE = 4;
    localparam int WC_MON = 5;
    localparam logic [31:0] WB_CFG_RESET = 32'h0000_029b;
endpackage

//--- hdl/daalic_link_if.sv
/*
 Link between the system-side controller and the line-side end.
 Assumes both ends share core_clk; the bench joins the two modports.
*/
`timescale 1ns/1ps
`default_nettype none
interface daalic_link_if
    import daalic_pkg::*;
(
    input wire logic core_clk
);
    logic linkPowerDown;
    logic sampleTick;
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] lineSideId;

    modport ctrl (output linkPowerDown, sampleTick, req, we, addr, wdata, input ack, rdata, lineSideId);
    modport line (input linkPowerDown, sampleTick, req, we, addr, wdata, output ack, rdata, lineSideId);
endinterface
`default_nettype wire

//--- hdl/daalic_line_side.sv
/*
 Line-side end: link registers, hook, termination, sense coding.
 Assumes the controller holds req until ack and owns the power-down bit.
*/
`timescale 1ns/1ps
`default_nettype none
module daalic_line_side
    import daalic_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // link
    daalic_link_if.line link,
    // analog measurements
    input wire logic [8:0] lineVoltQv,
    input wire logic [7:0] loopCurrentMa,
    input wire logic [4:0] monitorCode,
    input wire logic linePresent,
    // line controls
    output logic poweredUp,
    output logic hookSwitchOn,
    output logic [1:0] dcTermMode,
    output logic acTermComplex,
    output logic hookSpeedFast,
    output logic ringThresholdHigh,
    output logic reducedLineVEn,
    output logic dcImpedanceHigh,
    output logic termPinLow,
    output logic [2:0] txFullScale,
    output logic currentCapEn,
    output logic capEngaged,
    output logic lineDataValid
);
    logic [7:0] ctrl1_q;
    logic [7:0] line16_q;
    logic [7:0] line17_q;
    logic [7:0] line18_q;
    logic [4:0] code_q;
    logic dropout_q;
    logic ack_q;
    logic [7:0] rdata_q;
    logic [10:0] settle_q;
    logic [10:0] settle_d;
    logic hook_q, dcz_q, pinLow_q, act_q, hs_q, ring_q, rlv_q, cap_q, capHit_q, valid_q, pwr_q;
    logic [1:0] dct_q;
    logic [2:0] fs_q;

    // no traffic while the link is powered down
    wire take = link.req && !ack_q && !link.linkPowerDown;
    wire wr = take && link.we;
    wire [1:0] dc_term_select = line16_q[L16_DCT_LSB +: 2];
    wire hookReq = ctrl1_q[CTRL1_HOOK_BIT];
    wire monEn = ctrl1_q[CTRL1_MONITOR_BIT];
    wire senseMode = ctrl1_q[CTRL1_MODE_BIT];
    wire powered = !link.linkPowerDown;
    wire seize = hookReq && powered;

    // line voltage coding
    wire [8:0] lvDiv = lineVoltQv / LV_STEP_QV;
    wire [4:0] lvCode = (lineVoltQv < LV_ZERO_QV) ? CODE_ZERO :
                        (lineVoltQv >= LV_FULL_QV) ? CODE_OVER : lvDiv[4:0];
    // loop current coding
    wire [7:0] lcDiv = loopCurrentMa / LC_STEP_MA;
    wire [7:0] overMa = (dc_term_select == DCT_CTR21) ? LC_OVER_CTR21_MA : LC_OVER_MA;
    wire lcOver = loopCurrentMa > overMa;
    wire [4:0] lcCode = lcOver ? CODE_OVER :
                        (lcDiv >= {3'h0, CODE_TOP}) ? CODE_TOP : lcDiv[4:0];
    // off-hook: current, on-hook: monitor, voltage or zero
    wire [4:0] senseSel = hookReq ? lcCode :
                          monEn ? monitorCode :
                          senseMode ? lvCode : CODE_ZERO;
    wire [7:0] sense19 = (8'(dropout_q) << S19_DROPOUT_BIT) | (8'(code_q) << S19_CODE_LSB);

    wire [7:0] rdMux = (link.addr == REG_CTRL1) ? ctrl1_q :
                       (link.addr == REG_LINE16) ? line16_q :
                       (link.addr == REG_LINE17) ? line17_q :
                       (link.addr == REG_LINE18) ? line18_q :
                       (link.addr == REG_SENSE19) ? sense19 : 8'h00;

    wire [2:0] fsSel = line18_q[L18_FULL_BIT] ? FS_P3P2_DBM :
                       (dc_term_select == DCT_JAPAN) ? FS_M2P71_DBM :
                       (dc_term_select == DCT_LOWV) ? FS_M5_DBM : FS_M1_DBM;
    wire capOn = (dc_term_select == DCT_CTR21) && line17_q[L17_CAP_BIT];

    always_comb begin
        settle_d = settle_q;
        if (!seize) begin
            settle_d = 11'h000;
        end else if (link.sampleTick && settle_q != OFFHOOK_SETTLE_SAMPLES) begin
            settle_d = settle_q + 11'h001;
        end
    end

    // register file; defaults keep the line side idle
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrl1_q <= CTRL1_RESET;
            line16_q <= L16_RESET;
            line17_q <= L17_RESET;
            line18_q <= L18_RESET;
        end else if (wr) begin
            if (link.addr == REG_CTRL1) ctrl1_q <= link.wdata;
            if (link.addr == REG_LINE16) line16_q <= link.wdata;
            if (link.addr == REG_LINE17) line17_q <= link.wdata;
            if (link.addr == REG_LINE18) line18_q <= link.wdata;
        end
    end

    // status refreshed every cycle, writes never reach it
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            code_q <= CODE_ZERO;
            dropout_q <= 1'b0;
        end else begin
            code_q <= senseSel;
            dropout_q <= !linePresent;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            rdata_q <= 8'h00;
            settle_q <= 11'h000;
        end else begin
            ack_q <= take;
            if (take) rdata_q <= rdMux;
            settle_q <= settle_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pwr_q <= 1'b0;
            hook_q <= 1'b0;
            dct_q <= DCT_FCC;
            act_q <= 1'b0;
            hs_q <= 1'b0;
            ring_q <= 1'b0;
            rlv_q <= 1'b0;
            dcz_q <= 1'b0;
            pinLow_q <= 1'b0;
            fs_q <= FS_M1_DBM;
            cap_q <= 1'b0;
            capHit_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            pwr_q <= powered;
            hook_q <= seize;
            dct_q <= dc_term_select;
            act_q <= line16_q[L16_ACT_BIT];
            hs_q <= line16_q[L16_HS_BIT];
            ring_q <= line16_q[L16_RING_BIT];
            rlv_q <= line18_q[L18_RLV_BIT];
            dcz_q <= line16_q[L16_PAR_BIT];
            pinLow_q <= line16_q[L16_PAR_BIT];
            fs_q <= fsSel;
            cap_q <= capOn;
            capHit_q <= capOn && seize && (loopCurrentMa >= LC_CAP_MA - LC_STEP_MA);
            valid_q <= seize && (settle_d == OFFHOOK_SETTLE_SAMPLES);
        end
    end

    // identity is only visible once the link is up
    assign link.lineSideId = powered ? LINE_SIDE_ID : 8'h00;
    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    assign poweredUp = pwr_q;
    assign hookSwitchOn = hook_q;
    assign dcTermMode = dct_q;
    assign acTermComplex = act_q;
    assign hookSpeedFast = hs_q;
    assign ringThresholdHigh = ring_q;
    assign reducedLineVEn = rlv_q;
    assign dcImpedanceHigh = dcz_q;
    assign termPinLow = pinLow_q;
    assign txFullScale = fs_q;
    assign currentCapEn = cap_q;
    assign capEngaged = capHit_q;
    assign lineDataValid = valid_q;
endmodule
`default_nettype wire

//--- hdl/daalic_sys_ctrl.sv
/*
 System-side controller: wishbone slave, bring-up, id check, refresh.
 Assumes a classic wishbone master and the line end on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module daalic_sys_ctrl
    import daalic_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // monitor output enable
    output logic analogMonitorEn,
    // link
    daalic_link_if.ctrl link
);
    typedef enum {C_DOWN, C_LOCK, C_POWER, C_IDCHECK, C_RUN, C_FAULT} daalic_state_type;
    daalic_state_type state_q;
    logic ackq;
    logic [31:0] dat_q;
    logic [31:0] ctrl_q;
    logic [31:0] cfg_q;
    logic [7:0] ctrl2_q;
    logic [15:0] lockCnt_q;
    logic [11:0] tickCnt_q;
    logic [2:0] op_q;
    logic req_q;
    logic [7:0] wdata_q;
    logic ready_q;
    logic [4:0] code_q;
    logic dropout_q;

    wire access = wb_cyc_i && wb_stb_i;
    wire wbWr = access && wb_we_i && ackq;
    wire [7:0] rate = cfg_q[7:0];
    wire [1:0] dc_term_select = cfg_q[9:8];
    // boost forced off outside FCC termination
    wire fullEff = ctrl_q[WC_FULL] && (dc_term_select == DCT_FCC);
    wire lineLost = ctrl_q[WC_HOOK] && (code_q == CODE_ZERO) && dropout_q;
    wire [31:0] stat = {18'h0, dropout_q, code_q, 4'h0, (state_q != C_RUN && state_q != C_DOWN && state_q != C_FAULT),
                        lineLost, (state_q == C_FAULT), ready_q};
    wire [31:0] rdMux = (wb_adr_i == WB_CTRL) ? ctrl_q :
                        (wb_adr_i == WB_CFG) ? cfg_q :
                        (wb_adr_i == WB_STAT) ? stat : 32'h0;
    wire [31:0] selMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] ctrlNew = (ctrl_q & ~selMask) | (wb_dat_i & selMask);
    wire [31:0] cfgNew = (cfg_q & ~selMask) | (wb_dat_i & selMask);
    wire startCmd = wbWr && (wb_adr_i == WB_CTRL) && ctrlNew[WC_START];

    // (rate + 1) * 16 clocks per sample
    wire tick = (tickCnt_q == {rate, SAMPLE_SUB_MAX});
    wire lockDone = (lockCnt_q == 16'(PLL_LOCK_CYCLES - 1));

    wire [7:0] l16 = (8'(cfg_q[11]) << L16_HS_BIT) | (8'(cfg_q[10]) << L16_ACT_BIT) |
                     (8'(dc_term_select) << L16_DCT_LSB) | (8'(cfg_q[12]) << L16_RING_BIT) |
                     (8'(ctrl_q[WC_PAR]) << L16_PAR_BIT);
    wire [7:0] l17 = 8'(cfg_q[13]) << L17_CAP_BIT;
    wire [7:0] l18 = (8'(fullEff) << L18_FULL_BIT) | (8'(cfg_q[14]) << L18_RLV_BIT);
    wire [7:0] c1 = (8'(ctrl_q[WC_HOOK]) << CTRL1_HOOK_BIT) | (8'(ctrl_q[WC_MODE]) << CTRL1_MODE_BIT) |
                    (8'(ctrl_q[WC_MON]) << CTRL1_MONITOR_BIT);
    // country settings after power-up, then status read
    wire [4:0] opAddr = (op_q == 3'h0) ? REG_LINE16 : (op_q == 3'h1) ? REG_LINE17 :
                        (op_q == 3'h2) ? REG_LINE18 : (op_q == 3'h3) ? REG_CTRL1 : REG_SENSE19;
    wire [7:0] opData = (op_q == 3'h0) ? l16 : (op_q == 3'h1) ? l17 : (op_q == 3'h2) ? l18 : c1;
    wire opDone = req_q && link.ack;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ackq <= 1'b0;
            dat_q <= 32'h0;
            ctrl_q <= 32'h0;
            cfg_q <= WB_CFG_RESET;
        end else begin
            ackq <= access && !ackq;
            if (access && !ackq) dat_q <= rdMux;
            if (wbWr && wb_adr_i == WB_CTRL) ctrl_q <= ctrlNew & ~(32'h1 << WC_START);
            if (wbWr && wb_adr_i == WB_CFG) cfg_q <= cfgNew;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tickCnt_q <= 12'h000;
        end else begin
            tickCnt_q <= tick ? 12'h000 : tickCnt_q + 12'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= C_DOWN;
            ctrl2_q <= CTRL2_RESET;
            lockCnt_q <= 16'h0;
            op_q <= 3'h0;
            req_q <= 1'b0;
            ready_q <= 1'b0;
            code_q <= CODE_ZERO;
            dropout_q <= 1'b0;
        end else begin
            case (state_q)
                C_DOWN: begin
                    lockCnt_q <= 16'h0;
                    if (startCmd) state_q <= C_LOCK;
                end
                C_LOCK: begin
                    lockCnt_q <= lockCnt_q + 16'h1;
                    if (lockDone) state_q <= C_POWER;
                end
                C_POWER: begin
                    ctrl2_q <= CTRL2_POWER_ON;
                    state_q <= C_IDCHECK;
                end
                C_IDCHECK: begin
                    if (link.lineSideId == LINE_SIDE_ID) begin
                        state_q <= C_RUN;
                    end else begin
                        ctrl2_q <= CTRL2_RESET;
                        state_q <= C_FAULT;
                    end
                end
                C_RUN: begin
                    if (!req_q) begin
                        req_q <= 1'b1;
                        wdata_q <= opData;
                    end else if (opDone) begin
                        req_q <= 1'b0;
                        if (op_q == 3'h4) begin
                            code_q <= link.rdata[S19_CODE_LSB +: CODE_W];
                            dropout_q <= link.rdata[S19_DROPOUT_BIT];
                            ready_q <= 1'b1;
                            op_q <= 3'h0;
                        end else begin
                            op_q <= op_q + 3'h1;
                        end
                    end
                end
                C_FAULT: begin
                    req_q <= 1'b0;
                end
                default: begin
                    state_q <= C_DOWN;
                end
            endcase
        end
    end

    assign wb_ack_o = ackq;
    assign wb_dat_o = dat_q;
    assign analogMonitorEn = !ctrl2_q[CTRL2_MON_OFF_BIT];
    assign link.linkPowerDown = ctrl2_q[CTRL2_LINK_PD_BIT];
    assign link.sampleTick = tick;
    assign link.req = req_q;
    assign link.we = (op_q != 3'h4);
    assign link.addr = opAddr;
    assign link.wdata = wdata_q;
endmodule
`default_nettype wire

//--- tb/daalic_link_checker.sv
/*
 Concurrent checks on the link between the two ends.
 Assumes one core clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module daalic_link_checker
    import daalic_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // link
    input wire logic linkPowerDown,
    input wire logic sampleTick,
    input wire logic req,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic ack,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [DATA_W-1:0] lineSideId
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_take;
        req && !ack && !linkPowerDown;
    endsequence
    sequence s_answer;
        ack ##1 (!ack && !req);
    endsequence

    a_reset_link_down: assert property ($rose(resetn) |-> linkPowerDown) else $error("link up after reset");
    a_down_no_ack: assert property (linkPowerDown |=> !ack) else $error("ack while link down");
    a_take_answer: assert property (s_take |=> s_answer) else $error("answer late");
    a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request moved");
    a_id_shown: assert property (lineSideId == (linkPowerDown ? 8'h00 : LINE_SIDE_ID)) else $error("identity wrong");
    a_power_then_refresh: assert property ($fell(linkPowerDown) |-> ##[1:8] (req && we && addr == REG_LINE16))
        else $error("no refresh");
    a_tick_spaced: assert property (sampleTick |=> (!sampleTick) [*8]) else $error("ticks close");
    a_sense_read_only: assert property (req && addr == REG_SENSE19 |-> !we) else $error("sense register written");
    a_refresh_order: assert property (ack && we && addr == REG_CTRL1 |-> ##2 (req && !we && addr == REG_SENSE19))
        else $error("no sense read");
endmodule
`default_nettype wire

//--- tb/testbench.sv
/*
 Self-checking bench: wishbone host, line measurements, both link ends.
 Assumes the package constants and a 25 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(name, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin badCount++; \
    $display("Error %s expected %0h seen %0h", name, exp, got); end end
module testbench
    import daalic_pkg::*;
();
    logic core_clk;
    logic resetn = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDat;
    logic [31:0] wbDatO;
    logic wbAck;
    logic analogMonitorEn;
    logic [8:0] lineVoltQv = 9'h000;
    logic [7:0] loopCurrentMa = 8'h00;
    logic [4:0] monitorCode = 5'h00;
    logic linePresent = 1'b1;
    logic poweredUp, hookSwitchOn, acTermComplex, hookSpeedFast, ringThresholdHigh, reducedLineVEn;
    logic dcImpedanceHigh, termPinLow, currentCapEn, capEngaged, lineDataValid;
    logic [1:0] dcTermMode;
    logic [2:0] txFullScale;
    logic [31:0] rd;
    logic [8:0] qvT [4] = '{9'h00b, 9'h00c, 9'h15b, 9'h15c};
    logic [7:0] maT [4] = '{8'h3a, 8'h8d, 8'h00, 8'h36};
    int badCount = 0;
    int samplesChecked = 0;
    int seed = 32'h0621;

    daalic_link_if daalic_link_if_i (.core_clk(core_clk));
    daalic_sys_ctrl #(.PLL_LOCK_CYCLES(20)) daalic_sys_ctrl_i (.core_clk(core_clk), .resetn(resetn),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .analogMonitorEn(analogMonitorEn),
        .link(daalic_link_if_i));
    daalic_line_side daalic_line_side_i (.core_clk(core_clk), .resetn(resetn), .link(daalic_link_if_i),
        .lineVoltQv(lineVoltQv), .loopCurrentMa(loopCurrentMa), .monitorCode(monitorCode),
        .linePresent(linePresent), .poweredUp(poweredUp), .hookSwitchOn(hookSwitchOn),
        .dcTermMode(dcTermMode), .acTermComplex(acTermComplex), .hookSpeedFast(hookSpeedFast),
        .ringThresholdHigh(ringThresholdHigh), .reducedLineVEn(reducedLineVEn),
        .dcImpedanceHigh(dcImpedanceHigh), .termPinLow(termPinLow), .txFullScale(txFullScale),
        .currentCapEn(currentCapEn), .capEngaged(capEngaged), .lineDataValid(lineDataValid));
    daalic_link_checker daalic_link_checker_i (.core_clk(core_clk), .resetn(resetn),
        .linkPowerDown(daalic_link_if_i.linkPowerDown), .sampleTick(daalic_link_if_i.sampleTick),
        .req(daalic_link_if_i.req), .we(daalic_link_if_i.we), .addr(daalic_link_if_i.addr),
        .wdata(daalic_link_if_i.wdata), .ack(daalic_link_if_i.ack), .rdata(daalic_link_if_i.rdata),
        .lineSideId(daalic_link_if_i.lineSideId));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic completeRun();
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // classic single cycle
    task automatic wbAccess(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDat <= d;
        wbSel <= 4'hf;
        do begin
            @(posedge core_clk);
        end while (wbAck !== 1'b1);
        rd = wbDatO;
        `CHECK_EQ("wb ack", 1'b1, wbAck)
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    // two sense reads: one full loop after the last write
    task automatic waitRefresh();
        int n;
        int k;
        n = 0;
        k = 0;
        while (k < 2 && n < 400) begin
            @(posedge core_clk);
            n++;
            if (daalic_link_if_i.ack === 1'b1 && daalic_link_if_i.addr === REG_SENSE19) k++;
        end
        `CHECK_EQ("refresh", 2, k)
    endtask

    function automatic logic [4:0] expVolt(input logic [8:0] qv);
        if (qv < LV_ZERO_QV) return CODE_ZERO;
        if (qv >= LV_FULL_QV) return CODE_OVER;
        return 5'(qv / LV_STEP_QV);
    endfunction

    function automatic logic [4:0] expCurr(input logic [7:0] ma, input logic [1:0] dc_term_select);
        if (ma > ((dc_term_select == DCT_CTR21) ? LC_OVER_CTR21_MA : LC_OVER_MA)) return CODE_OVER;
        if (ma / LC_STEP_MA > 8'(CODE_TOP)) return CODE_TOP;
        return 5'(ma / LC_STEP_MA);
    endfunction

    function automatic logic [2:0] expFs(input logic full, input logic [1:0] dc_term_select);
        if (dc_term_select == DCT_FCC) return full ? FS_P3P2_DBM : FS_M1_DBM;
        if (dc_term_select == DCT_CTR21) return FS_M1_DBM;
        return (dc_term_select == DCT_JAPAN) ? FS_M2P71_DBM : FS_M5_DBM;
    endfunction

    initial begin
        #4000000;
        badCount++;
        $display("Error watchdog expected finish seen timeout");
        completeRun();
    end

    initial begin
        logic [1:0] dc_term_select;
        logic [1:0] m;
        logic [4:0] expCode;
        logic [7:0] bits;
        int n;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        `CHECK_EQ("poweredUp", 1'b0, poweredUp)
        `CHECK_EQ("hookSwitchOn", 1'b0, hookSwitchOn)
        `CHECK_EQ("dcTermMode", DCT_FCC, dcTermMode)
        `CHECK_EQ("txFullScale", FS_M1_DBM, txFullScale)
        `CHECK_EQ("analogMonitorEn", 1'b0, analogMonitorEn)
        wbAccess(1'b0, WB_CFG, 32'h0);
        `CHECK_EQ("cfg reset", WB_CFG_RESET, rd)
        wbAccess(1'b1, 8'h0c, 32'hffff_ffff);
        wbAccess(1'b0, 8'h0c, 32'h0);
        `CHECK_EQ("unmapped read", 32'h0, rd)
        // hook while link down must not seize
        wbAccess(1'b1, WB_CTRL, 32'h2);
        wbAccess(1'b0, WB_STAT, 32'h0);
        `CHECK_EQ("hook while down", 1'b0, hookSwitchOn)
        wbAccess(1'b1, WB_CTRL, 32'h0);
        wbAccess(1'b1, WB_CTRL, 32'h1);
        wbAccess(1'b0, WB_STAT, 32'h0);
        `CHECK_EQ("busy in lock wait", 1'b1, rd[3])
        `CHECK_EQ("down in lock wait", 1'b0, poweredUp)
        n = 0;
        do begin
            wbAccess(1'b0, WB_STAT, 32'h0);
            n++;
        end while (rd[0] !== 1'b1 && n < 100);
        `CHECK_EQ("ready", 1'b1, rd[0])
        `CHECK_EQ("fault", 1'b0, rd[1])
        `CHECK_EQ("analogMonitorEn", 1'b1, analogMonitorEn)
        `CHECK_EQ("poweredUp", 1'b1, poweredUp)
        for (int i = 0; i < 8; i++) begin
            dc_term_select = 2'(i);
            bits = 8'($random(seed));
            wbAccess(1'b1, WB_CFG, {17'h0, bits[4:0], dc_term_select, RATE_RESET});
            wbAccess(1'b1, WB_CTRL, {28'h0, bits[6:5], 2'b00});
            waitRefresh();
            `CHECK_EQ("dcTermMode", dc_term_select, dcTermMode)
            `CHECK_EQ("acTermComplex", bits[0], acTermComplex)
            `CHECK_EQ("hookSpeedFast", bits[1], hookSpeedFast)
            `CHECK_EQ("ringThresholdHigh", bits[2], ringThresholdHigh)
            `CHECK_EQ("reducedLineVEn", bits[4], reducedLineVEn)
            `CHECK_EQ("currentCapEn", bits[3] && dc_term_select == DCT_CTR21, currentCapEn)
            `CHECK_EQ("txFullScale", expFs(bits[5], dc_term_select), txFullScale)
            `CHECK_EQ("dcImpedanceHigh", bits[6], dcImpedanceHigh)
            `CHECK_EQ("termPinLow", bits[6], termPinLow)
        end
        // fastest rate before off-hook
        wbAccess(1'b1, WB_CFG, {22'h0, DCT_FCC, 8'h00});
        waitRefresh();
        wbAccess(1'b1, WB_CTRL, 32'h2);
        n = 0;
        while (hookSwitchOn !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        n = 0;
        while (lineDataValid !== 1'b1 && n < 2000) begin
            @(posedge core_clk);
            if (daalic_link_if_i.sampleTick === 1'b1) n++;
        end
        `CHECK_EQ("settle ticks", 1'b1, n >= 1546 && n <= 1550)
        wbAccess(1'b1, WB_CTRL, 32'h0);
        waitRefresh();
        `CHECK_EQ("lineDataValid", 1'b0, lineDataValid)
        `CHECK_EQ("on-hook", 1'b0, hookSwitchOn)
        for (int j = 0; j < 16; j++) begin
            m = 2'(j);
            dc_term_select = j[2] ? DCT_FCC : DCT_CTR21;
            lineVoltQv <= qvT[j / 4];
            loopCurrentMa <= (m == 2'h3) ? maT[j / 4] : 8'($random(seed));
            monitorCode <= 5'($random(seed));
            linePresent <= (j != 11);
            wbAccess(1'b1, WB_CFG, {17'h0, 5'h08, dc_term_select, RATE_RESET});
            wbAccess(1'b1, WB_CTRL, {26'h0, m == 2'h1, m == 2'h0, 2'b00, m == 2'h3, 1'b0});
            waitRefresh();
            wbAccess(1'b0, WB_STAT, 32'h0);
            expCode = (m == 2'h3) ? expCurr(loopCurrentMa, dc_term_select) : (m == 2'h1) ? monitorCode :
                (m == 2'h0) ? expVolt(lineVoltQv) : CODE_ZERO;
            `CHECK_EQ("sense code", expCode, rd[12:8])
            `CHECK_EQ("dropout", !linePresent, rd[13])
            `CHECK_EQ("line lost", m == 2'h3 && expCode == CODE_ZERO && !linePresent, rd[2])
            `CHECK_EQ("hookSwitchOn", m == 2'h3, hookSwitchOn)
            `CHECK_EQ("capEngaged", m == 2'h3 && dc_term_select == DCT_CTR21 && loopCurrentMa >= 8'h39, capEngaged)
        end
        completeRun();
    end
endmodule
`default_nettype wire
